// ==== src/thcp_defines.svh ====
// timing counts and command codes for the tape host command port
// assumes the includer works on a 250 MHz system clock
`ifndef THCP_DEFINES_SVH
`define THCP_DEFINES_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define THCP_CLK_MHZ        250
`define THCP_ONE_US         1
`define THCP_US_CYC         (`THCP_ONE_US * `THCP_CLK_MHZ)
`define THCP_SPEED_CHG_US   20
`define THCP_SPEED_CHG_CYC  (`THCP_SPEED_CHG_US * `THCP_CLK_MHZ)

// ----------------------------------------------------------------
// functional command codes, bit 4 down to bit 0
// ----------------------------------------------------------------
`define THCP_READ_FWD       5'h00
`define THCP_READ_REV       5'h08
`define THCP_READ_SENSE     5'h19
`define THCP_WRITE          5'h04
`define THCP_WRITE_MARK     5'h06
`define THCP_WRITE_EXT      5'h0e
`define THCP_CTRL_ERASE     5'h05
`define THCP_FIXED_ERASE    5'h07
`define THCP_SEC_ERASE      5'h17
`define THCP_SPACE_FWD      5'h01
`define THCP_SPACE_REV      5'h09
`define THCP_SEARCH_FWD     5'h03
`define THCP_SEARCH_REV     5'h0b
`define THCP_SEL_PE         5'h13
`define THCP_SEL_GCR        5'h12

// ----------------------------------------------------------------
// diagnostic command codes
// ----------------------------------------------------------------
`define THCP_DIAG_INVOKE    5'h0c
`define THCP_LOOP_WR_RD     5'h0f
`define THCP_STATUS_SEQ     5'h10
`define THCP_CMD_WRAP       5'h11
`define THCP_EXT_SENSE      5'h1d
`define THCP_DATA_LOOP      5'h1f

`endif

// ==== src/thcp_pkg.sv ====
// types for the tape host command port
// assumes thcp_defines.svh carries the numbers
package thcp_pkg;

	// ----------------------------------------------------------------
	// operation classes from command decode
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		THCP_OP_NONE  = 3'b000,
		THCP_OP_READ  = 3'b001,
		THCP_OP_WRITE = 3'b010,
		THCP_OP_MOVE  = 3'b011,
		THCP_OP_ERASE = 3'b100,
		THCP_OP_DIAG  = 3'b101,
		THCP_OP_MODE  = 3'b110
	} thcp_op_t;

	// ----------------------------------------------------------------
	// command sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		THCP_ST_IDLE  = 3'b000,
		THCP_ST_SPEED = 3'b001,
		THCP_ST_XFER  = 3'b010,
		THCP_ST_TAIL  = 3'b011,
		THCP_ST_RWND  = 3'b100,
		THCP_ST_UNLD  = 3'b101
	} thcp_state_t;

endpackage

// ==== src/thcp_sync.sv ====
// two-stage synchroniser for a vector of asynchronous pin inputs
// assumes the pins are quasi-static against sys_clk
`timescale 1ns/10ps

module thcp_sync #(
	parameter int W = 1
) (
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_q;

	// ----------------------------------------------------------------
	// two flops, first read only by second
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= pin_in;
			sync_out <= meta_q;
		end
	end

endmodule

// ==== src/thcp_port.sv ====
// tape host command port: go strobe, offline, enable, status outputs
// assumes host pins are asynchronous and tape mechanics report via pins
//
// Overview of operation
// - go-offline drops ready after 1 us, then goes offline, rewinds, unloads.
// - go-offline ignored when offline or formatter busy.
// - enable falling while online stops motion, ends command; offline ignored.
// - accepting a new command clears overrun, hard error and corrected error status.
// - write data is eight lines, bit zero most significant, plus parity.
// - speed select picks 100 or 50 IPS; change speed before executing.
// - long gap adds 0.3 inch to the gap, only at 100 IPS.
// - five command lines decode to 15 functional, 6 diagnostic operations.
// - functional command codes decode per fixed table.
// - diagnostic command codes decode per fixed table.
// - busy rises within 1 us of go, holds until command completes.
// - data busy only in transfer; new command queued till previous done.
// - error pulses hard error low while busy, then holds it low.
// - corrected error pulses, held low after data busy, cleared next record.
// - ready only when loaded, not rewinding, not machine check.
// - online shown when online; offline forces other status off.
// - end of tape set at marker, cleared at marker going backward.
// - command lines latched on go trailing edge; go held 1 us.
// - go during data busy sets overrun and is ignored; offline ignored.
`timescale 1ns/10ps
`include "thcp_defines.svh"

module thcp_port #(
	parameter int US_CYC       = `THCP_US_CYC,
	parameter int SPEED_CHG_CYC = `THCP_SPEED_CHG_CYC
) (
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic       go_strobe,
	input  wire logic [4:0] cmd_bits,
	input  wire logic       go_offline_req,
	input  wire logic       formatter_enable_in,
	input  wire logic       final_byte_flag,
	input  wire logic [8:0] wr_data_bus,
	input  wire logic       speed_select,
	input  wire logic       long_gap_req,
	input  wire logic       online_sw,
	input  wire logic       tape_loaded,
	input  wire logic       rewind_done,
	input  wire logic       machine_check,
	input  wire logic       xfer_done,
	input  wire logic       motion_done,
	input  wire logic       err_detect,
	input  wire logic       corr_event,
	input  wire logic       eot_marker,
	input  wire logic       tape_reverse,
	output logic            formatter_busy_out,
	output logic            xfer_busy_out,
	output logic            hard_err_n_out,
	output logic            corrected_err_n_out,
	output logic            unit_ready,
	output logic            online_stat,
	output logic            rewinding_out,
	output logic            end_of_tape_out,
	output logic            high_speed_out,
	output logic            cmd_overrun_out,
	output logic            motion_run_out,
	output logic            unload_out,
	output logic            long_gap_out,
	output logic            cmd_valid_out,
	output logic [4:0]      cmd_code_out,
	output logic [2:0]      cmd_class_out,
	output logic [8:0]      wr_byte_out,
	output logic            wr_last_out
);

	// ----------------------------------------------------------------
	// synchronisers
	// ----------------------------------------------------------------
	localparam int NS = 22;
	logic [NS-1:0] raw_w;
	logic [NS-1:0] syn_w;
	assign raw_w = {go_strobe, cmd_bits, go_offline_req,
		formatter_enable_in, final_byte_flag, wr_data_bus,
		speed_select, long_gap_req, online_sw, eot_marker};

	thcp_sync #(.W(NS)) u_sync (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.pin_in   (raw_w),
		.sync_out (syn_w)
	);

	logic       go_s;
	logic [4:0] cmd_s;
	logic       ofl_s;
	logic       en_s;
	logic       last_s;
	logic [8:0] wd_s;
	logic       hisp_s;
	logic       lgap_s;
	logic       onsw_s;
	logic       eot_s;
	assign {go_s, cmd_s, ofl_s, en_s, last_s, wd_s, hisp_s, lgap_s,
		onsw_s, eot_s} = syn_w;

	// ----------------------------------------------------------------
	// edge detect and state registers
	// ----------------------------------------------------------------
	logic                 go_q;
	logic                 ofl_q;
	logic                 en_q;
	logic                 eot_q;
	logic                 online_q;
	logic                 busy_q;
	logic                 hispd_q;
	logic [4:0]           cmd_q;
	logic                 pend_q;
	logic [4:0]           pend_cmd_q;
	logic                 ofl_pend_q;
	logic [15:0]          ofl_cnt_q;
	logic [15:0]          spd_cnt_q;
	logic                 hard_q;
	logic                 corr_q;
	logic                 eot_stat_q;
	logic                 ready_kill_q;
	logic                 ovr_q;
	thcp_pkg::thcp_state_t st_q;
	thcp_pkg::thcp_state_t st_d;

	wire go_rise   = go_s & ~go_q;
	wire go_fall   = ~go_s & go_q;
	wire ofl_rise  = ofl_s & ~ofl_q;
	wire en_fall   = ~en_s & en_q;
	wire eot_rise  = eot_s & ~eot_q;
	wire in_xfer   = (st_q == thcp_pkg::THCP_ST_XFER);
	wire idle      = (st_q == thcp_pkg::THCP_ST_IDLE);

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	function automatic thcp_pkg::thcp_op_t decode(input logic [4:0] c);
		thcp_pkg::thcp_op_t r;
		r = thcp_pkg::THCP_OP_NONE;
		case (c)
			`THCP_READ_FWD, `THCP_READ_REV,
			`THCP_READ_SENSE:  r = thcp_pkg::THCP_OP_READ;
			`THCP_WRITE, `THCP_WRITE_MARK,
			`THCP_WRITE_EXT:   r = thcp_pkg::THCP_OP_WRITE;
			`THCP_CTRL_ERASE, `THCP_FIXED_ERASE,
			`THCP_SEC_ERASE:   r = thcp_pkg::THCP_OP_ERASE;
			`THCP_SPACE_FWD, `THCP_SPACE_REV,
			`THCP_SEARCH_FWD,
			`THCP_SEARCH_REV:  r = thcp_pkg::THCP_OP_MOVE;
			`THCP_SEL_PE, `THCP_SEL_GCR:
				r = thcp_pkg::THCP_OP_MODE;
			`THCP_DIAG_INVOKE, `THCP_LOOP_WR_RD, `THCP_STATUS_SEQ,
			`THCP_CMD_WRAP, `THCP_EXT_SENSE,
			`THCP_DATA_LOOP:   r = thcp_pkg::THCP_OP_DIAG;
			default:           r = thcp_pkg::THCP_OP_NONE;
		endcase
		return r;
	endfunction

	wire thcp_pkg::thcp_op_t op_w = decode(pend_cmd_q);
	wire moves  = (op_w != thcp_pkg::THCP_OP_MODE) &&
		(op_w != thcp_pkg::THCP_OP_DIAG);
	wire xfers  = (op_w == thcp_pkg::THCP_OP_READ) ||
		(op_w == thcp_pkg::THCP_OP_WRITE) ||
		(op_w == thcp_pkg::THCP_OP_DIAG);

	// go accepted on trailing edge; refused while data busy or offline
	wire go_ok      = go_fall & online_q & ~in_xfer & ~pend_q;
	wire go_overrun = go_rise & online_q & in_xfer;
	wire start_cmd  = idle & pend_q & online_q & en_s;
	wire spd_diff   = (hisp_s != hispd_q) & moves;
	wire abort      = en_fall & online_q;
	wire ofl_ok     = ofl_rise & online_q & ~busy_q & idle;
	wire ofl_fire   = ofl_pend_q &&
		(ofl_cnt_q == 16'(US_CYC - 1));

	// ----------------------------------------------------------------
	// sequencer next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		case (st_q)
			thcp_pkg::THCP_ST_IDLE: begin
				if (ofl_fire)
					st_d = thcp_pkg::THCP_ST_RWND;
				else if (start_cmd && spd_diff)
					st_d = thcp_pkg::THCP_ST_SPEED;
				else if (start_cmd)
					st_d = xfers ? thcp_pkg::THCP_ST_XFER
						: thcp_pkg::THCP_ST_TAIL;
			end
			thcp_pkg::THCP_ST_SPEED: begin
				if (spd_cnt_q == 16'(SPEED_CHG_CYC - 1))
					st_d = xfers ? thcp_pkg::THCP_ST_XFER
						: thcp_pkg::THCP_ST_TAIL;
			end
			thcp_pkg::THCP_ST_XFER: begin
				if (xfer_done)
					st_d = thcp_pkg::THCP_ST_TAIL;
			end
			thcp_pkg::THCP_ST_TAIL: begin
				if (motion_done)
					st_d = thcp_pkg::THCP_ST_IDLE;
			end
			thcp_pkg::THCP_ST_RWND: begin
				if (rewind_done)
					st_d = thcp_pkg::THCP_ST_UNLD;
			end
			thcp_pkg::THCP_ST_UNLD: st_d = thcp_pkg::THCP_ST_IDLE;
			default: st_d = thcp_pkg::THCP_ST_IDLE;
		endcase
		if (abort && !idle && st_q != thcp_pkg::THCP_ST_RWND &&
			st_q != thcp_pkg::THCP_ST_UNLD)
			st_d = thcp_pkg::THCP_ST_IDLE;
	end

	// ----------------------------------------------------------------
	// sequencer and control registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			go_q       <= 1'b0;
			ofl_q      <= 1'b0;
			en_q       <= 1'b0;
			eot_q      <= 1'b0;
			st_q       <= thcp_pkg::THCP_ST_IDLE;
			pend_q     <= 1'b0;
			pend_cmd_q <= 5'h00;
			cmd_q      <= 5'h00;
			hispd_q    <= 1'b0;
			spd_cnt_q  <= 16'h0000;
		end else begin
			go_q  <= go_s;
			ofl_q <= ofl_s;
			en_q  <= en_s;
			eot_q <= eot_s;
			st_q  <= st_d;
			if (go_ok) begin
				pend_q     <= 1'b1;
				pend_cmd_q <= cmd_s;
			end else if (start_cmd || abort || !online_q) begin
				pend_q <= 1'b0;
			end
			if (start_cmd)
				cmd_q <= pend_cmd_q;
			if (st_q == thcp_pkg::THCP_ST_SPEED)
				spd_cnt_q <= spd_cnt_q + 16'h0001;
			else
				spd_cnt_q <= 16'h0000;
			if (start_cmd && moves)
				hispd_q <= hisp_s;
		end
	end

	// ----------------------------------------------------------------
	// online, offline request and busy
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			online_q     <= 1'b0;
			ofl_pend_q   <= 1'b0;
			ofl_cnt_q    <= 16'h0000;
			ready_kill_q <= 1'b0;
			busy_q       <= 1'b0;
		end else begin
			if (ofl_ok) begin
				ofl_pend_q   <= 1'b1;
				ofl_cnt_q    <= 16'h0000;
			end else if (ofl_pend_q) begin
				ofl_cnt_q <= ofl_cnt_q + 16'h0001;
				if (ofl_fire) begin
					ofl_pend_q   <= 1'b0;
					ready_kill_q <= 1'b1;
				end
			end
			if (st_q == thcp_pkg::THCP_ST_RWND && ready_kill_q)
				online_q <= 1'b0;
			else if (onsw_s && idle && !ofl_pend_q && !ready_kill_q)
				online_q <= 1'b1;
			if (st_q == thcp_pkg::THCP_ST_UNLD)
				ready_kill_q <= 1'b0;
			// busy from go leading edge, well inside 1 us
			if (go_rise && online_q && !in_xfer)
				busy_q <= 1'b1;
			else if (st_d == thcp_pkg::THCP_ST_IDLE && !pend_q &&
				!go_ok && !go_s)
				busy_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// status flags
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			hard_q     <= 1'b0;
			corr_q     <= 1'b0;
			ovr_q      <= 1'b0;
			eot_stat_q <= 1'b0;
		end else begin
			// set wins over clear-on-accept
			if (go_overrun)
				ovr_q <= 1'b1;
			else if (start_cmd)
				ovr_q <= 1'b0;
			if (err_detect && busy_q)
				hard_q <= 1'b1;
			else if (start_cmd)
				hard_q <= 1'b0;
			if (corr_event && in_xfer)
				corr_q <= 1'b1;
			else if (start_cmd)
				corr_q <= 1'b0;
			if (eot_rise && !tape_reverse &&
				st_q != thcp_pkg::THCP_ST_RWND)
				eot_stat_q <= 1'b1;
			else if (eot_rise)
				eot_stat_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// registered outputs, offline masks status outputs but not motion run, unload, long gap, command or write outputs
	// ----------------------------------------------------------------
	wire on_w    = online_q;
	wire rwnd_w  = (st_q == thcp_pkg::THCP_ST_RWND);
	wire pulse_h = busy_q & err_detect;
	wire pulse_c = corr_event & in_xfer;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			formatter_busy_out  <= 1'b0;
			xfer_busy_out       <= 1'b0;
			hard_err_n_out      <= 1'b1;
			corrected_err_n_out <= 1'b1;
			unit_ready          <= 1'b0;
			online_stat         <= 1'b0;
			rewinding_out       <= 1'b0;
			end_of_tape_out     <= 1'b0;
			high_speed_out      <= 1'b0;
			cmd_overrun_out     <= 1'b0;
			motion_run_out      <= 1'b0;
			unload_out          <= 1'b0;
			long_gap_out        <= 1'b0;
			cmd_valid_out       <= 1'b0;
			cmd_code_out        <= 5'h00;
			cmd_class_out       <= 3'h0;
			wr_byte_out         <= 9'h000;
			wr_last_out         <= 1'b0;
		end else begin
			online_stat        <= on_w;
			formatter_busy_out <= on_w & busy_q;
			xfer_busy_out      <= on_w & in_xfer;
			// pulsed low while busy, solid low once not busy
			hard_err_n_out <= ~(on_w & ((busy_q & pulse_h) |
				(hard_q & ~busy_q)));
			corrected_err_n_out <= ~(on_w & (pulse_c |
				(corr_q & ~in_xfer)));
			unit_ready <= on_w & tape_loaded & ~rwnd_w &
				~machine_check & ~ready_kill_q &
				~ofl_fire;
			rewinding_out   <= on_w & rwnd_w;
			end_of_tape_out <= on_w & eot_stat_q;
			high_speed_out  <= on_w & hispd_q;
			cmd_overrun_out <= on_w & ovr_q;
			motion_run_out  <= ~idle & (st_q !=
				thcp_pkg::THCP_ST_UNLD) & ~abort;
			unload_out      <= (st_q == thcp_pkg::THCP_ST_UNLD);
			long_gap_out    <= lgap_s & hispd_q;
			cmd_valid_out   <= start_cmd;
			if (start_cmd) begin
				cmd_code_out  <= pend_cmd_q;
				cmd_class_out <= op_w;
			end
			wr_byte_out <= wd_s;
			wr_last_out <= last_s & in_xfer &
				(decode(cmd_q) == thcp_pkg::THCP_OP_WRITE);
		end
	end

endmodule

// ==== test/thcp_port_monitor.sv ====
// checker on the pins of thcp_port
// assumes it is bound into every thcp_port instance
`timescale 1ns/10ps

module thcp_port_monitor #(
	parameter int US_CYC = 4
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic go_strobe,
	input wire logic go_offline_req,
	input wire logic formatter_enable_in,
	input wire logic machine_check,
	input wire logic tape_loaded,
	input wire logic err_detect,
	input wire logic rewind_done,
	input wire logic formatter_busy_out,
	input wire logic xfer_busy_out,
	input wire logic hard_err_n_out,
	input wire logic corrected_err_n_out,
	input wire logic unit_ready,
	input wire logic online_stat,
	input wire logic rewinding_out,
	input wire logic cmd_overrun_out,
	input wire logic motion_run_out,
	input wire logic unload_out,
	input wire logic cmd_valid_out
);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	localparam int RDY_WIN = US_CYC + 6;
	logic rwnd_seen_q;

	// rewind seen, armed until unload
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			rwnd_seen_q <= 1'b0;
		else if (rewinding_out)
			rwnd_seen_q <= 1'b1;
		else if (unload_out)
			rwnd_seen_q <= 1'b0;
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	chk_busy_on_go: assert property (
		$rose(go_strobe) && online_stat && formatter_enable_in
		|-> ##[1:5] formatter_busy_out) else $error("busy late");
	chk_ready_drop: assert property (
		$rose(go_offline_req) && online_stat && unit_ready
		&& !formatter_busy_out |-> unit_ready[*4] ##[1:RDY_WIN] !unit_ready)
		else $error("ready drop timing");
	chk_offline_quiet: assert property (
		!online_stat && !$past(online_stat)
		|-> !unit_ready && !xfer_busy_out && !cmd_overrun_out)
		else $error("status while offline");
	chk_ready_cond: assert property (
		(machine_check || !tape_loaded)[*2] |=> !unit_ready)
		else $error("ready without load");
	chk_xfer_in_busy: assert property (
		xfer_busy_out |-> formatter_busy_out) else $error("xfer not busy");
	chk_status_clear: assert property (
		cmd_valid_out |-> formatter_busy_out ##1 (!cmd_overrun_out
		&& hard_err_n_out && corrected_err_n_out))
		else $error("stale status");
	chk_overrun_set: assert property (
		$rose(go_strobe) && xfer_busy_out |-> ##[1:5] cmd_overrun_out)
		else $error("no overrun");
	chk_hard_err: assert property (
		err_detect && formatter_busy_out |-> ##[1:2] !hard_err_n_out)
		else $error("hard error missed");
	chk_enable_abort: assert property (
		$fell(formatter_enable_in) && online_stat && xfer_busy_out
		|-> ##[1:6] !xfer_busy_out && !motion_run_out) else $error("no abort");
	chk_unload: assert property (
		rewind_done && rwnd_seen_q |-> ##[1:3] unload_out)
		else $error("no unload");
endmodule

bind thcp_port thcp_port_monitor #(.US_CYC(US_CYC)) u_mon (.*);

// ==== test/thcp_host_model.sv ====
// host controller model driving the command pins
// assumes the bench calls its tasks at falling clock edges
`timescale 1ns/10ps

module thcp_host_model #(
	parameter int HOLD = 6
) (
	input  wire logic sys_clk,
	input  wire logic xfer_busy_out,
	output logic      go_strobe,
	output logic [4:0] cmd_bits,
	output logic      go_offline_req,
	output logic      formatter_enable_in,
	output logic      final_byte_flag,
	output logic [8:0] wr_data_bus,
	output logic      speed_select,
	output logic      long_gap_req
);
	// ----------------------------------------------------------------
	// pin drivers
	// ----------------------------------------------------------------
	initial begin
		{go_strobe, go_offline_req, final_byte_flag} = 3'h0;
		{speed_select, long_gap_req, cmd_bits, wr_data_bus} = 16'h0;
		formatter_enable_in = 1'b1;
	end
	task automatic send_go(input logic [4:0] c, input bit ovr);
		while (!ovr && xfer_busy_out !== 1'b0) @(negedge sys_clk);
		cmd_bits = c;
		@(negedge sys_clk);
		go_strobe = 1'b1;
		repeat (HOLD) @(negedge sys_clk);
		go_strobe = 1'b0;
		repeat (4) @(negedge sys_clk);
		cmd_bits = ~c;
	endtask
	task automatic offline;
		go_offline_req = 1'b1;
		repeat (HOLD) @(negedge sys_clk);
		go_offline_req = 1'b0;
	endtask
	task automatic put_byte(input logic [8:0] b, input logic last);
		wr_data_bus = b;
		final_byte_flag = last;
	endtask
	task automatic set_mode(input logic s, input logic g);
		speed_select = s;
		long_gap_req = g;
	endtask
	task automatic set_enable(input logic e);
		formatter_enable_in = e;
	endtask
endmodule

// ==== test/thcp_port_tb_top.sv ====
// self-checking bench for thcp_port
// assumes the host model and the monitor are compiled before it
`timescale 1ns/10ps

module thcp_port_tb_top;
	logic       sys_clk, rst_n, online_sw, tape_loaded, rewind_done;
	logic       machine_check, xfer_done, motion_done, err_detect;
	logic       corr_event, eot_marker, tape_reverse, go_strobe;
	logic       go_offline_req, formatter_enable_in, final_byte_flag;
	logic       speed_select, long_gap_req, formatter_busy_out;
	logic       xfer_busy_out, hard_err_n_out, corrected_err_n_out;
	logic       unit_ready, online_stat, rewinding_out, end_of_tape_out;
	logic       high_speed_out, cmd_overrun_out, motion_run_out;
	logic       unload_out, long_gap_out, cmd_valid_out, wr_last_out;
	logic [4:0] cmd_bits, cmd_code_out;
	logic [8:0] wr_data_bus, wr_byte_out, b;
	logic [2:0] cmd_class_out;
	logic [7:0] exp_q[$];
	logic [7:0] got;
	logic       spd, gap;
	int         fail_count, checked, n;
	logic [4:0] codes [21] = '{5'h00, 5'h08, 5'h19, 5'h04, 5'h06, 5'h0e,
		5'h05, 5'h07, 5'h17, 5'h01, 5'h09, 5'h03, 5'h0b, 5'h13, 5'h12,
		5'h0c, 5'h0f, 5'h10, 5'h11, 5'h1d, 5'h1f};

	thcp_port #(.US_CYC(4), .SPEED_CHG_CYC(8)) dut (.*);
	thcp_host_model host (.*);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [2:0] cls(input logic [4:0] c);
		case (c)
			5'h00, 5'h08, 5'h19: return thcp_pkg::THCP_OP_READ;
			5'h04, 5'h06, 5'h0e: return thcp_pkg::THCP_OP_WRITE;
			5'h05, 5'h07, 5'h17: return thcp_pkg::THCP_OP_ERASE;
			5'h01, 5'h09, 5'h03, 5'h0b: return thcp_pkg::THCP_OP_MOVE;
			5'h13, 5'h12: return thcp_pkg::THCP_OP_MODE;
			default: return thcp_pkg::THCP_OP_DIAG;
		endcase
	endfunction
	task automatic chk(input logic [9:0] g, input logic [9:0] e,
		input string what);
		checked++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, g, e);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(negedge sys_clk);
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge sys_clk);
		s = 1'b0;
	endtask
	task automatic wait_start;
		for (n = 0; n < 60 && exp_q.size() != 0; n++) @(negedge sys_clk);
		chk(9'(exp_q.size()), 9'h0, "no start");
	endtask
	task automatic start_cmd(input logic [4:0] c);
		exp_q.push_back({cls(c), c});
		host.send_go(c, 1'b0);
		wait_start();
		tick(12);
	endtask
	task automatic end_cmd(input logic xf);
		if (xf) begin
			chk(xfer_busy_out, 9'h1, "xfer");
			tick(3);
			pulse(xfer_done);
			tick(2);
			chk({xfer_busy_out, formatter_busy_out}, 9'h1, "tail");
		end
		pulse(motion_done);
		tick(3);
		chk(formatter_busy_out, 9'h0, "busy end");
	endtask
	task automatic stop_test;
		$display("checks %0d failures %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// clock, decode watcher, watchdog
	// ----------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	always @(negedge sys_clk) begin
		if (cmd_valid_out === 1'b1) begin
			got = (exp_q.size() != 0) ? exp_q.pop_front() : 8'hff;
			chk({cmd_class_out, cmd_code_out}, got, "decode");
		end
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		fail_count++;
		$display("[FAIL] %0t watchdog expired", $time);
		stop_test();
	end

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		{rst_n, online_sw, rewind_done, machine_check, xfer_done} = 5'h0;
		{motion_done, err_detect, corr_event, eot_marker} = 4'h0;
		tape_reverse = 1'b0;
		tape_loaded = 1'b1;
		void'($urandom(96062));
		tick(20);
		rst_n = 1'b1;
		tick(1);
		chk({hard_err_n_out, corrected_err_n_out, online_stat}, 9'h6, "rst");
		online_sw = 1'b1;
		tick(6);
		chk({online_stat, unit_ready}, 9'h3, "online");
		machine_check = 1'b1;
		tick(4);
		chk(unit_ready, 9'h0, "mchk");
		machine_check = 1'b0;
		tick(4);
		foreach (codes[i]) begin
			spd = 1'($urandom_range(1, 0));
			gap = 1'($urandom_range(1, 0));
			b = 9'($urandom_range(511, 0));
			host.set_mode(spd, gap);
			host.put_byte(b, 1'(i));
			start_cmd(codes[i]);
			chk({wr_last_out, wr_byte_out},
				{1'(i) & (cls(codes[i]) == 3'h2), b}, "wr");
			if (cls(codes[i]) inside {3'h1, 3'h2}) begin
				chk(high_speed_out, spd, "speed");
				chk(long_gap_out, spd & gap, "gap");
			end
			end_cmd(cls(codes[i]) inside {3'h1, 3'h2, 3'h5});
		end
		start_cmd(5'h04);
		pulse(xfer_done);
		exp_q.push_back({3'h1, 5'h00});
		host.send_go(5'h00, 1'b0);
		tick(4);
		chk(9'(exp_q.size()), 9'h1, "queued");
		pulse(motion_done);
		wait_start();
		pulse(err_detect);
		pulse(corr_event);
		end_cmd(1'b1);
		chk(hard_err_n_out, 9'h0, "hard err");
		chk(corrected_err_n_out, 9'h0, "corr err");
		start_cmd(5'h08);
		chk({hard_err_n_out, corrected_err_n_out}, 9'h3, "clr");
		host.send_go(5'h08, 1'b1);
		chk(cmd_overrun_out, 9'h1, "overrun");
		end_cmd(1'b1);
		start_cmd(5'h04);
		chk(cmd_overrun_out, 9'h0, "ovr clr");
		host.set_enable(1'b0);
		tick(6);
		chk({xfer_busy_out, motion_run_out}, 9'h0, "abort");
		host.set_enable(1'b1);
		pulse(motion_done);
		tick(4);
		start_cmd(5'h01);
		host.offline();
		tick(6);
		chk({unit_ready, online_stat}, 9'h3, "busy ofl");
		end_cmd(1'b0);
		eot_marker = 1'b1;
		tick(5);
		chk(end_of_tape_out, 9'h1, "eot set");
		eot_marker = 1'b0;
		tape_reverse = 1'b1;
		tick(5);
		chk(end_of_tape_out, 9'h1, "eot hold");
		eot_marker = 1'b1;
		tick(5);
		chk(end_of_tape_out, 9'h0, "eot clr");
		{eot_marker, tape_reverse} = 2'h0;
		fork
			host.offline();
		join_none
		tick(3);
		chk(unit_ready, 9'h1, "ready early");
		tick(5);
		chk({unit_ready, rewinding_out}, 9'h1, "ready late");
		online_sw = 1'b0;
		tick(10);
		chk({online_stat, rewinding_out}, 9'h0, "rewind");
		pulse(rewind_done);
		for (n = 0; n < 10 && unload_out !== 1'b1; n++) @(negedge sys_clk);
		chk(unload_out, 9'h1, "unload");
		host.send_go(5'h00, 1'b0);
		tick(10);
		chk({formatter_busy_out, online_stat}, 9'h0, "offline go");
		stop_test();
	end
endmodule
